// File: common/rid_pkg.sv
// shared constants and carrier types for the return-instruction decoder
package rid_pkg;
	localparam int OP_W = 14;
	localparam int PC_W = 13;
	localparam int LIT_W = 8;
	// fixed opcodes and pattern fields
	localparam logic [13:0] RETI_OPCODE = 14'h0009;
	localparam logic [13:0] RET_OPCODE = 14'h0008;
	localparam logic [13:0] RETLIT_MASK = 14'h3C00;
	localparam logic [13:0] RETLIT_MATCH = 14'h3400;
	localparam int GIE_BIT = 7;
	localparam int EXEC_CYCLES = 2;
	localparam logic [1:0] CYC_RESET = 2'h0;

	typedef enum logic [1:0] {
		RID_NONE,
		RID_RETI,
		RID_RETLIT,
		RID_RET
	} rid_kind_type;

	// decoded instruction
	typedef struct packed {
		logic         hit;
		rid_kind_type kind;
		logic [7:0]   literal;
	} rid_dec_type;

	// write-back commands toward core state
	typedef struct packed {
		logic        pop;
		logic        pc_load;
		logic [12:0] pc_value;
		logic        w_load;
		logic [7:0]  w_value;
		logic        gie_set;
	} rid_wb_type;
endpackage

// File: src/rid_opdec.sv
// combinational opcode matcher for the three return instructions
`timescale 1ns/1ps
`default_nettype none
module rid_opdec (
	input  wire logic [13:0]         opcode_i,
	output rid_pkg::rid_dec_type     dec_o
);
	always_comb begin
		dec_o = '0;
		dec_o.kind = rid_pkg::RID_NONE;
		if (opcode_i == rid_pkg::RETI_OPCODE) begin
			dec_o.hit = 1'b1;
			dec_o.kind = rid_pkg::RID_RETI;
		end else if (opcode_i == rid_pkg::RET_OPCODE) begin
			dec_o.hit = 1'b1;
			dec_o.kind = rid_pkg::RID_RET;
		end else if ((opcode_i & rid_pkg::RETLIT_MASK) == rid_pkg::RETLIT_MATCH) begin
			dec_o.hit = 1'b1;
			dec_o.kind = rid_pkg::RID_RETLIT;
			dec_o.literal = opcode_i[7:0];
		end
	end
endmodule
`default_nettype wire

// File: src/rid_return_exec.sv
// decode and two-cycle execution of the return-type instructions
// Functional notes
// - opcode 0x0009 is return from interrupt: pop stack, top_of_stack to PC.
// - return from interrupt sets global_interrupt_enable, bit 7 of interrupt control.
// - return from interrupt is one word, two cycles, status flags untouched.
// - pattern 11 01xx kkkk kkkk loads the 8-bit literal into W.
// - return with literal pops stack into PC, status flags untouched.
// - return with literal is one word and completes in two cycles.
// - plain return pops stack into PC, no operands, no status change.
// - plain return takes two instruction cycles.
`timescale 1ns/1ps
`default_nettype none
module rid_return_exec (
	input  wire logic                mclk_i,
	input  wire logic                rst_i,
	input  wire logic                issue_i,
	input  wire logic [13:0]         opcode_i,
	input  wire logic [12:0]         top_of_stack_i,
	output logic                     accept_o,
	output logic                     busy_o,
	output logic                     fetch_stall_o,
	output rid_pkg::rid_wb_type      wb_o,
	output logic                     done_o,
	output logic                     flags_write_o
);
	rid_pkg::rid_dec_type dec;
	logic [1:0]           cyc_reg;
	rid_pkg::rid_kind_type kind_reg;
	logic [7:0]           lit_reg;
	logic                 take;

	rid_opdec u_dec (
		.opcode_i (opcode_i),
		.dec_o    (dec)
	);

	////////////////////////////////////////////////////////////////////////
	// issue handshake
	assign accept_o = dec.hit && !busy_o;
	assign take = issue_i && accept_o;
	assign busy_o = (cyc_reg != rid_pkg::CYC_RESET);
	// second cycle flushes the fetched word, like any branch
	assign fetch_stall_o = busy_o;
	// no return instruction touches arithmetic flags
	assign flags_write_o = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// cycle counter: cycle 1 at take, cycle 2 completes
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cyc_reg <= rid_pkg::CYC_RESET;
		end else if (take) begin
			cyc_reg <= 2'h1;
		end else if (busy_o) begin
			if (cyc_reg == 2'(rid_pkg::EXEC_CYCLES - 1)) begin
				cyc_reg <= rid_pkg::CYC_RESET;
			end else begin
				cyc_reg <= cyc_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			kind_reg <= rid_pkg::RID_NONE;
			lit_reg <= 8'h00;
		end else if (take) begin
			kind_reg <= dec.kind;
			lit_reg <= dec.literal;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write-back registered at the end of the first cycle
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wb_o <= '0;
		end else begin
			wb_o <= '0;
			if (take) begin
				wb_o.pop <= 1'b1;
				wb_o.pc_load <= 1'b1;
				wb_o.pc_value <= top_of_stack_i;
				wb_o.w_load <= (dec.kind == rid_pkg::RID_RETLIT);
				wb_o.w_value <= dec.literal;
				wb_o.gie_set <= (dec.kind == rid_pkg::RID_RETI);
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			done_o <= 1'b0;
		end else begin
			done_o <= busy_o && (cyc_reg == 2'(rid_pkg::EXEC_CYCLES - 1));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	pop_once_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		take |=> wb_o.pop && wb_o.pc_load ##1 !wb_o.pop)
		else $error("return did not pop exactly once");
	gie_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		wb_o.gie_set |-> wb_o.pop && $past(opcode_i) == rid_pkg::RETI_OPCODE)
		else $error("interrupt enable set without return from interrupt");
	two_cycle_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		take |=> busy_o ##1 !busy_o && done_o)
		else $error("return did not take two cycles");
	lit_load_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		take && dec.kind == rid_pkg::RID_RETLIT |=> wb_o.w_load
		&& wb_o.w_value == $past(opcode_i[7:0]))
		else $error("literal not loaded into W");
	pc_value_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		take |=> wb_o.pc_value == $past(top_of_stack_i))
		else $error("PC not loaded from top of stack");
	no_reissue_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		busy_o |-> !accept_o)
		else $error("accepted during execution");
	plain_ret_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		take && dec.kind == rid_pkg::RID_RET |=> !wb_o.w_load && !wb_o.gie_set)
		else $error("plain return changed W or interrupt enable");
	done_timing_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		done_o |-> $past(take, 2))
		else $error("completion not two cycles after issue");
	dont_care_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		opcode_i[13:10] == 4'hD |-> dec.kind == rid_pkg::RID_RETLIT)
		else $error("don't-care bits changed decode");
	no_flags_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		busy_o |-> !flags_write_o)
		else $error("status flags written");
endmodule
`default_nettype wire

// File: dv/rid_stack_model.sv
// far-side return stack model that serves return addresses
`timescale 1ns/1ps
`default_nettype none
module rid_stack_model (
	input  wire logic                mclk_i,
	input  wire logic                rst_i,
	input  wire rid_pkg::rid_wb_type wb_i,
	output logic [12:0]              top_of_stack_o
);
	// every pop exposes a different return address
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			top_of_stack_o <= 13'h1ABC;
		end else if (wb_i.pop) begin
			top_of_stack_o <= top_of_stack_o - 13'h0123;
		end
	end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the return-instruction decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                mclk_i = 1'b0;
	logic                rst_i = 1'b1;
	logic                issue_i = 1'b0;
	logic [13:0]         opcode_i = 14'h0000;
	logic [12:0]         top_of_stack_i;
	logic [12:0]         top_of_stack;
	logic                accept_o, busy_o, fetch_stall_o, done_o, flags_write_o;
	rid_pkg::rid_wb_type wb_o;
	int                  num_errors = 0;
	int                  checks = 0;
	always #2 mclk_i = ~mclk_i;
	rid_return_exec rid_return_exec_inst (.mclk_i(mclk_i), .rst_i(rst_i), .issue_i(issue_i),
		.opcode_i(opcode_i), .top_of_stack_i(top_of_stack_i), .accept_o(accept_o),
		.busy_o(busy_o), .fetch_stall_o(fetch_stall_o), .wb_o(wb_o), .done_o(done_o),
		.flags_write_o(flags_write_o));
	rid_stack_model rid_stack_model_inst (.mclk_i(mclk_i), .rst_i(rst_i), .wb_i(wb_o),
		.top_of_stack_o(top_of_stack_i));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one issue, then write-back cycle, then completion cycle
	task automatic run(input logic [13:0] op, input logic w, input logic g);
		@(posedge mclk_i);
		issue_i <= 1'b1;
		opcode_i <= op;
		#1 chk(accept_o, 1'b1);
		top_of_stack = top_of_stack_i;
		@(posedge mclk_i);
		issue_i <= 1'b0;
		#1 chk({wb_o.pop, wb_o.pc_load, busy_o, fetch_stall_o, accept_o}, 5'h1E);
		chk(wb_o.pc_value, top_of_stack);
		chk({wb_o.w_load, wb_o.gie_set, flags_write_o}, {w, g, 1'b0});
		if (w) chk(wb_o.w_value, op[7:0]);
		@(posedge mclk_i);
		#1 chk({done_o, busy_o, wb_o.pop}, 3'h4);
	endtask
	task automatic t_reti;
		run(14'h0009, 1'b0, 1'b1);
		$display("test return_from_interrupt_op ended");
	endtask
	task automatic t_retlit;
		for (int i = 0; i < 4; i++) begin
			run({4'hD, i[1:0], (i[0] ? 8'hFF : 8'h00)}, 1'b1, 1'b0);
		end
		$display("test return_with_literal_op ended");
	endtask
	task automatic t_ret;
		run(14'h0008, 1'b0, 1'b0);
		$display("test plain return ended");
	endtask
	task automatic t_refuse(input logic [13:0] op);
		@(posedge mclk_i);
		issue_i <= 1'b1;
		opcode_i <= op;
		#1 chk(accept_o, 1'b0);
		@(posedge mclk_i);
		issue_i <= 1'b0;
		#1 chk({wb_o.pop, busy_o}, 2'h0);
		@(posedge mclk_i);
		#1 chk(done_o, 1'b0);
		$display("test refused opcode ended");
	endtask
	task automatic print_verdict;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk_i);
		rst_i <= 1'b0;
		#1 chk({accept_o, busy_o, done_o, wb_o.pop}, 4'h0);
		t_reti();
		t_retlit();
		t_ret();
		t_refuse(14'h3000);
		t_refuse(14'h000A);
		print_verdict();
	end
	initial begin
		#4000;
		num_errors++;
		print_verdict();
	end
endmodule
`default_nettype wire
